// ---- rtl/slta_encoder.sv ----
// slta_encoder: user-data stage of a transmit data link layer, one lane.
// assumes: pclk is the frame octet clock, inputs are synchronous to it,
// the receiver drives link_sync_request_n low to request synchronisation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - after alignment sequence, frames carry user data
// - scrambling on after reset, software can disable
// - scrambled frame end 0xFC becomes frame alignment
// - scrambled multiframe end 0xFD becomes lane alignment
// - unscrambled repeated frame end octet gets replaced
// - alignment insertion on after reset, software controlled
// - 8b10b coding with running disparity tracking
// - multiframe start, lane alignment, group sync codes
// - config start and frame alignment codes
// - group sync symbol depends on running disparity
// - two-bit encoder bypass and invert test field
// - lanes powered up after reset
// - two's complement after reset, format selectable
// - de-emphasis off until software enables it
// - pll lock readable in status bit seven
// - complex mode: I to first, Q to second virtual converter
// - up to four downconverters, eight virtual converters
// - alignment sequence starts on next multiframe boundary
// - self-sync scrambler, alignment sequence unscrambled
module slta_encoder
  import slta_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_sync_request_n,
  input wire logic serdes_pll_locked,
  input wire logic [NUM_DCONV*SAMPLE_W-1:0] dconv_i_data,
  input wire logic [NUM_DCONV*SAMPLE_W-1:0] dconv_q_data,
  output logic [9:0] lane_symbol,
  output logic lane_power_up,
  output logic [3:0] lane_rate_ctrl,
  output logic deemph_enable,
  output logic [3:0] deemph_level,
  output logic local_multiframe_clock
);
  // ----------------------------------------
  // coding functions
  // ----------------------------------------
  function automatic logic [10:0] enc_8b10b(input logic k, input logic [7:0] d, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic rd1;
    logic a7;
    logic [4:0] x;
    logic [2:0] y;
    x = d[4:0];
    y = d[7:5];
    unique case (x)
      5'd0: s6 = 6'b100111;
      5'd1: s6 = 6'b011101;
      5'd2: s6 = 6'b101101;
      5'd3: s6 = 6'b110001;
      5'd4: s6 = 6'b110101;
      5'd5: s6 = 6'b101001;
      5'd6: s6 = 6'b011001;
      5'd7: s6 = 6'b111000;
      5'd8: s6 = 6'b111001;
      5'd9: s6 = 6'b100101;
      5'd10: s6 = 6'b010101;
      5'd11: s6 = 6'b110100;
      5'd12: s6 = 6'b001101;
      5'd13: s6 = 6'b101100;
      5'd14: s6 = 6'b011100;
      5'd15: s6 = 6'b010111;
      5'd16: s6 = 6'b011011;
      5'd17: s6 = 6'b100011;
      5'd18: s6 = 6'b010011;
      5'd19: s6 = 6'b110010;
      5'd20: s6 = 6'b001011;
      5'd21: s6 = 6'b101010;
      5'd22: s6 = 6'b011010;
      5'd23: s6 = 6'b111010;
      5'd24: s6 = 6'b110011;
      5'd25: s6 = 6'b100110;
      5'd26: s6 = 6'b010110;
      5'd27: s6 = 6'b110110;
      5'd28: s6 = 6'b001110;
      5'd29: s6 = 6'b101110;
      5'd30: s6 = 6'b011110;
      5'd31: s6 = 6'b101011;
    endcase
    // only K28.y control characters exist on this link
    if (k)
      s6 = 6'b001111;
    if ($countones(s6) != 3)
    begin
      if (rd)
        s6 = ~s6;
      rd1 = ~rd;
    end
    else
    begin
      if (x == 5'd7 && rd)
        s6 = 6'b000111;
      rd1 = rd;
    end
    a7 = (y == 3'd7) && (k || (!rd1 && (x == 5'd17 || x == 5'd18 || x == 5'd20))
         || (rd1 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    unique case (y)
      3'd0: s4 = 4'b1011;
      3'd1: s4 = 4'b1001;
      3'd2: s4 = 4'b0101;
      3'd3: s4 = 4'b1100;
      3'd4: s4 = 4'b1101;
      3'd5: s4 = 4'b1010;
      3'd6: s4 = 4'b0110;
      3'd7: s4 = a7 ? 4'b0111 : 4'b1110;
    endcase
    if ($countones(s4) != 2 || y == 3'd3)
    begin
      if (rd1)
        s4 = ~s4;
    end
    else if (k && !rd1)
      s4 = ~s4;
    return {(($countones(s4) != 2) ? ~rd1 : rd1), s6, s4};
  endfunction

  // self-synchronising 1 + x^14 + x^15, msb first
  function automatic logic [22:0] scramble(input logic [14:0] st, input logic [7:0] d);
    logic [14:0] s;
    logic [7:0] o;
    s = st;
    o = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ s[14] ^ s[13];
      s = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [1:0] fmt_sel;
  logic power_down;
  logic insert_en;
  logic [1:0] enc_test;
  logic scr_en;
  logic [3:0] f_m1;
  logic [4:0] k_m1;
  logic [1:0] dconv_m1;
  logic dconv_real;
  logic pll_lock_q;
  slta_state_e state;
  slta_state_e next_state;

  wire logic [11:0] reg_idx = paddr[ADDR_W-1:2];
  wire logic access = psel && penable;
  wire logic wr_take = access && pready && pwrite;
  wire logic rd_hit = (reg_idx == IDX_OUT_FORMAT) || (reg_idx == IDX_LANE_RATE) ||
                      (reg_idx == IDX_PLL_STATUS) || (reg_idx == IDX_LINK_CTRL) ||
                      (reg_idx == IDX_ENC_CTRL) || (reg_idx == IDX_LINK_PARAMS) ||
                      (reg_idx == IDX_DEEMPH_EN) || (reg_idx == IDX_DEEMPH_LVL);
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (1'b1)
      reg_idx == IDX_OUT_FORMAT: rd_word[1:0] = fmt_sel;
      reg_idx == IDX_LANE_RATE: rd_word[POS_LANE_RATE+:4] = lane_rate_ctrl;
      reg_idx == IDX_PLL_STATUS: rd_word[7:0] = {pll_lock_q, 5'h00, state};
      reg_idx == IDX_LINK_CTRL: rd_word[7:0] = {3'h0, insert_en, 3'h0, power_down};
      reg_idx == IDX_ENC_CTRL: rd_word[2:1] = enc_test;
      reg_idx == IDX_LINK_PARAMS: rd_word[15:0] = {scr_en, dconv_real, dconv_m1, f_m1, 3'h0, k_m1};
      reg_idx == IDX_DEEMPH_EN: rd_word[0] = deemph_enable;
      reg_idx == IDX_DEEMPH_LVL: rd_word[3:0] = deemph_level;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // one wait state: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access && !pready;
      if (access && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= !rd_hit;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_sel <= RST_OUT_FORMAT;
      lane_rate_ctrl <= RST_LANE_RATE;
      power_down <= RST_POWER_DOWN;
      insert_en <= RST_INSERT_EN;
      enc_test <= RST_ENC_TEST;
      scr_en <= RST_SCR_EN;
      f_m1 <= RST_F_M1;
      k_m1 <= RST_K_M1;
      dconv_m1 <= RST_DCONV_M1;
      dconv_real <= RST_DCONV_REAL;
      deemph_enable <= RST_DEEMPH_EN;
      deemph_level <= RST_DEEMPH_LVL;
    end
    else if (wr_take)
    begin
      unique case (1'b1)
        reg_idx == IDX_OUT_FORMAT: fmt_sel <= pwdata[1:0];
        reg_idx == IDX_LANE_RATE: lane_rate_ctrl <= pwdata[POS_LANE_RATE+:4];
        reg_idx == IDX_LINK_CTRL:
        begin
          power_down <= pwdata[POS_POWER_DOWN];
          insert_en <= pwdata[POS_INSERT_EN];
        end
        reg_idx == IDX_ENC_CTRL: enc_test <= pwdata[2:1];
        reg_idx == IDX_LINK_PARAMS:
        begin
          scr_en <= pwdata[POS_SCR_EN];
          dconv_real <= pwdata[POS_DCONV_REAL];
          dconv_m1 <= pwdata[13:12];
          f_m1 <= pwdata[11:8];
          k_m1 <= pwdata[4:0];
        end
        reg_idx == IDX_DEEMPH_EN: deemph_enable <= pwdata[0];
        reg_idx == IDX_DEEMPH_LVL: deemph_level <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // frame and multiframe position
  // ----------------------------------------
  logic [3:0] oct_cnt;
  logic [4:0] frm_cnt;
  logic [7:0] ramp;
  logic [1:0] ilas_mf;
  wire logic frame_end = (oct_cnt == f_m1);
  wire logic mf_end = frame_end && (frm_cnt == k_m1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oct_cnt <= 4'h0;
      frm_cnt <= 5'h00;
      ramp <= 8'h00;
      local_multiframe_clock <= 1'b0;
      pll_lock_q <= 1'b0;
      lane_power_up <= 1'b1;
    end
    else
    begin
      oct_cnt <= frame_end ? 4'h0 : oct_cnt + 4'h1;
      if (frame_end)
        frm_cnt <= mf_end ? 5'h00 : frm_cnt + 5'h01;
      ramp <= mf_end ? 8'h00 : ramp + 8'h01;
      local_multiframe_clock <= mf_end;
      pll_lock_q <= serdes_pll_locked;
      lane_power_up <= !power_down;
    end
  end

  // ----------------------------------------
  // virtual converter mapping
  // ----------------------------------------
  logic [SAMPLE_W-1:0] vc_live [NUM_VC];
  logic [SAMPLE_W-1:0] vc_word [NUM_VC];
  wire logic [2:0] dconv_used = {1'b0, dconv_m1} + 3'h1;
  for (genvar v = 0; v < NUM_VC; v++)
  begin : g_vc
    localparam logic [2:0] VC = 3'(v);
    wire logic [1:0] src = dconv_real ? VC[1:0] : VC[2:1];
    wire logic in_use = dconv_real ? (v < NUM_DCONV && VC < dconv_used) : ({1'b0, VC[2:1]} < dconv_used);
    wire logic [SAMPLE_W-1:0] raw = (dconv_real || !VC[0]) ? dconv_i_data[src*SAMPLE_W+:SAMPLE_W]
                                                           : dconv_q_data[src*SAMPLE_W+:SAMPLE_W];
    wire logic [SAMPLE_W-1:0] fmt = (fmt_sel == FMT_OFFSET) ? {~raw[SAMPLE_W-1], raw[SAMPLE_W-2:0]} : raw;
    assign vc_live[v] = in_use ? fmt : '0;
  end

  // samples for the next frame are caught on the last octet
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int v = 0; v < NUM_VC; v++)
        vc_word[v] <= '0;
    end
    else if (frame_end)
    begin
      for (int v = 0; v < NUM_VC; v++)
        vc_word[v] <= vc_live[v];
    end
  end

  wire logic [SAMPLE_W-1:0] cur_word = vc_word[oct_cnt[3:1]];
  wire logic [7:0] user_oct = oct_cnt[0] ? cur_word[7:0] : cur_word[15:8];

  // ----------------------------------------
  // link sequence
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_CGS: if (link_sync_request_n && mf_end) next_state = ST_ILAS;
      ST_ILAS:
        if (!link_sync_request_n)
          next_state = ST_CGS;
        else if (mf_end && ilas_mf == ILAS_LAST_MF)
          next_state = ST_DATA;
      ST_DATA: if (!link_sync_request_n) next_state = ST_CGS;
    endcase
  end

  // ----------------------------------------
  // character selection and substitution
  // ----------------------------------------
  logic [14:0] scr_state;
  logic [7:0] prev_last;
  logic rd_pos;
  logic tx_k;
  logic [7:0] tx_oct;
  wire logic [22:0] scr_res = scramble(scr_state, user_oct);
  wire logic [7:0] data_oct = scr_en ? scr_res[7:0] : user_oct;
  wire logic sub_a = insert_en && mf_end && (scr_en ? (data_oct == MATCH_MFRAME) : (data_oct == prev_last));
  wire logic sub_f = insert_en && frame_end && !sub_a &&
                     (scr_en ? (data_oct == MATCH_FRAME) : (data_oct == prev_last) && !mf_end);
  logic next_k;
  logic [7:0] next_oct;
  always_comb
  begin
    next_k = 1'b1;
    next_oct = K_GROUP_SYNC;
    unique case (state)
      ST_CGS: next_oct = K_GROUP_SYNC;
      ST_ILAS:
        if (ramp == 8'h00)
          next_oct = K_MF_START;
        else if (mf_end)
          next_oct = K_LANE_ALIGN;
        else if (ilas_mf == 2'h1 && ramp == ILAS_CFG_POS)
          next_oct = K_CFG_START;
        else
        begin
          next_k = 1'b0;
          next_oct = ramp;
        end
      ST_DATA:
        if (sub_a)
          next_oct = K_LANE_ALIGN;
        else if (sub_f)
          next_oct = K_FRAME_ALIGN;
        else
        begin
          next_k = 1'b0;
          next_oct = data_oct;
        end
    endcase
  end

  wire logic [10:0] enc = enc_8b10b(next_k, next_oct, rd_pos);
  wire logic [9:0] pre_sym = enc_test[1] ? {1'b0, next_k, next_oct} : enc[9:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_CGS;
      ilas_mf <= 2'h0;
      scr_state <= RST_SCR_STATE;
      prev_last <= 8'h00;
      rd_pos <= 1'b0;
      tx_k <= 1'b0;
      tx_oct <= 8'h00;
      lane_symbol <= 10'h000;
    end
    else
    begin
      state <= next_state;
      ilas_mf <= (state != ST_ILAS) ? 2'h0 : (mf_end ? ilas_mf + 2'h1 : ilas_mf);
      if (state == ST_DATA)
        scr_state <= scr_res[22:8];
      if (state == ST_DATA && frame_end)
        prev_last <= data_oct;
      rd_pos <= enc[10];
      tx_k <= next_k;
      tx_oct <= next_oct;
      lane_symbol <= enc_test[0] ? ~pre_sym : pre_sym;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_ilas_on_boundary: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_CGS && next_state == ST_ILAS) |-> mf_end ##2 (tx_oct == K_MF_START && tx_k))
    else $error("alignment sequence did not start at multiframe boundary");
  chk_scram_frame_sub: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DATA && scr_en && insert_en && frame_end && !mf_end && data_oct == MATCH_FRAME)
    |=> (tx_k && tx_oct == K_FRAME_ALIGN))
    else $error("scrambled 0xFC at frame end not replaced");
  chk_scram_mf_sub: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DATA && scr_en && insert_en && mf_end && data_oct == MATCH_MFRAME)
    |=> (tx_k && tx_oct == K_LANE_ALIGN))
    else $error("scrambled 0xFD at multiframe end not replaced");
  chk_plain_repeat: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DATA && !scr_en && insert_en && frame_end && data_oct == prev_last)
    |=> (tx_k && tx_oct == ($past(mf_end) ? K_LANE_ALIGN : K_FRAME_ALIGN)))
    else $error("repeated frame end octet not replaced");
  chk_user_passes: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_DATA && !frame_end) |=> (!tx_k && tx_oct == $past(data_oct)))
    else $error("mid frame user octet altered");
  chk_disp_balance: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(enc_test) == 2'h0 && $past(presetn)) |->
    ($countones(lane_symbol) == 5 || ($countones(lane_symbol) == 6 && !$past(rd_pos))
     || ($countones(lane_symbol) == 4 && $past(rd_pos))))
    else $error("symbol breaks running disparity");
  chk_gsync_code: assert property (@(posedge pclk) disable iff (!presetn)
    (next_k && next_oct == K_GROUP_SYNC && enc_test == 2'h0)
    |=> (lane_symbol == ($past(rd_pos) ? SYM_GS_RDPOS : SYM_GS_RDNEG)))
    else $error("group sync symbol wrong for disparity");
  chk_pll_readback: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pready && !pwrite && reg_idx == IDX_PLL_STATUS)
    |=> (pready && prdata[POS_PLL_LOCK] == $past(pll_lock_q)))
    else $error("pll lock status not returned");
  chk_iq_pairing: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_end && !dconv_real) |=> (vc_word[0] == $past(vc_live[0]) && vc_word[1] == $past(vc_live[1])
     && ($past(fmt_sel) != FMT_TWOS || vc_word[1] == $past(dconv_q_data[SAMPLE_W-1:0]))))
    else $error("quadrature stream not on second converter");
endmodule // slta_encoder

`default_nettype wire

// ---- rtl/slta_pkg.sv ----
// slta_pkg: constants shared by the lane alignment and encoder block.
// assumes: APB word addressing, register index times four is the byte address.
package slta_pkg;
  // ----------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------
  localparam logic [11:0] IDX_OUT_FORMAT = 12'h561;
  localparam logic [11:0] IDX_LANE_RATE = 12'h56E;
  localparam logic [11:0] IDX_PLL_STATUS = 12'h56F;
  localparam logic [11:0] IDX_LINK_CTRL = 12'h571;
  localparam logic [11:0] IDX_ENC_CTRL = 12'h572;
  localparam logic [11:0] IDX_LINK_PARAMS = 12'h580;
  localparam logic [11:0] IDX_DEEMPH_EN = 12'h5C4;
  localparam logic [11:0] IDX_DEEMPH_LVL = 12'h5C6;
  localparam int ADDR_W = 14;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int POS_PLL_LOCK = 7;
  localparam int POS_POWER_DOWN = 0;
  localparam int POS_INSERT_EN = 4;
  localparam int POS_ENC_INVERT = 1;
  localparam int POS_ENC_BYPASS = 2;
  localparam int POS_SCR_EN = 15;
  localparam int POS_DCONV_REAL = 14;
  localparam int POS_LANE_RATE = 4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0] RST_OUT_FORMAT = 2'h0;
  localparam logic [3:0] RST_LANE_RATE = 4'h0;
  localparam logic RST_POWER_DOWN = 1'b0;
  localparam logic RST_INSERT_EN = 1'b1;
  localparam logic [1:0] RST_ENC_TEST = 2'h0;
  localparam logic RST_SCR_EN = 1'b1;
  localparam logic [3:0] RST_F_M1 = 4'h1;
  localparam logic [4:0] RST_K_M1 = 5'h1F;
  localparam logic [1:0] RST_DCONV_M1 = 2'h3;
  localparam logic RST_DCONV_REAL = 1'b0;
  localparam logic RST_DEEMPH_EN = 1'b0;
  localparam logic [3:0] RST_DEEMPH_LVL = 4'h0;
  localparam logic [14:0] RST_SCR_STATE = 15'h0000;
  // ----------------------------------------
  // output sample formats
  // ----------------------------------------
  localparam logic [1:0] FMT_TWOS = 2'h0;
  localparam logic [1:0] FMT_OFFSET = 2'h1;
  // ----------------------------------------
  // control characters (unencoded, control flag set)
  // ----------------------------------------
  localparam logic [7:0] K_MF_START = 8'h1C;
  localparam logic [7:0] K_LANE_ALIGN = 8'h7C;
  localparam logic [7:0] K_CFG_START = 8'h9C;
  localparam logic [7:0] K_GROUP_SYNC = 8'hBC;
  localparam logic [7:0] K_FRAME_ALIGN = 8'hFC;
  localparam logic [7:0] MATCH_FRAME = 8'hFC;
  localparam logic [7:0] MATCH_MFRAME = 8'hFD;
  localparam logic [9:0] SYM_GS_RDNEG = 10'h0FA;
  localparam logic [9:0] SYM_GS_RDPOS = 10'h305;
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;
  localparam logic [7:0] ILAS_CFG_POS = 8'h01;
  localparam int NUM_DCONV = 4;
  localparam int NUM_VC = 8;
  localparam int SAMPLE_W = 16;

  typedef enum logic [1:0] {ST_CGS, ST_ILAS, ST_DATA} slta_state_e;
endpackage

// ---- tb/slta_rx_model.sv ----
// slta_rx_model: behavioural link receiver facing the lane output.
// assumes: one symbol per pclk, comma run of four releases the sync request.
`timescale 1ns/1ps
`default_nettype none
module slta_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [9:0] lane_symbol,
  input wire logic force_resync,
  output logic link_sync_request_n
);
  logic [2:0] k_run;
  logic [4:0] hold;
  wire logic is_comma;
  assign is_comma = (lane_symbol == 10'h0FA) || (lane_symbol == 10'h305);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      k_run <= 3'h0;
      hold <= 5'h0;
      link_sync_request_n <= 1'b0;
    end
    else if (force_resync)
    begin
      // held past four frames so the transmitter must fully resync
      hold <= 5'h1F;
      k_run <= 3'h0;
      link_sync_request_n <= 1'b0;
    end
    else if (hold != 5'h0)
      hold <= hold - 5'h1;
    else if (!link_sync_request_n)
    begin
      k_run <= is_comma ? k_run + {2'h0, k_run != 3'h4} : 3'h0;
      link_sync_request_n <= (k_run == 3'h4);
    end
  end
endmodule // slta_rx_model
`default_nettype wire

// ---- tb/slta_encoder_tb.sv ----
// slta_encoder_tb: register and lane checks for the alignment encoder.
// assumes: slta_rx_model answers the sync request, APB master below.
`timescale 1ns/1ps
`default_nettype none
module slta_encoder_tb
  import slta_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, pwr, dee, mfc, er;
  logic pll = 1'b0;
  logic frc = 1'b1;
  logic rd_on = 1'b1;
  logic seen = 1'b0;
  logic [63:0] di = 64'h4D3C_2B1A_5E6F_1234;
  logic [63:0] dq = 64'h0000_0000_0000_5678;
  logic [9:0] sym;
  logic [9:0] first_ilas = 10'h0;
  logic [9:0] oct [0:4];
  logic [3:0] rate, lvl;
  logic [31:0] rd;
  wire logic sync_n;
  int err_count = 0;
  int check_count = 0;
  int acc = 0;
  logic [11:0] ridx [0:6] = '{IDX_OUT_FORMAT, IDX_LANE_RATE, IDX_LINK_CTRL, IDX_ENC_CTRL, IDX_LINK_PARAMS,
    IDX_DEEMPH_EN, IDX_DEEMPH_LVL};
  logic [31:0] rexp [0:6] = '{32'h0, 32'h0, 32'h10, 32'h0, 32'hB11F, 32'h0, 32'h0};

  always #12.5 pclk = ~pclk;

  slta_encoder slta_encoder_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_sync_request_n(sync_n), .serdes_pll_locked(pll), .dconv_i_data(di), .dconv_q_data(dq),
    .lane_symbol(sym), .lane_power_up(pwr), .lane_rate_ctrl(rate), .deemph_enable(dee),
    .deemph_level(lvl), .local_multiframe_clock(mfc));
  slta_rx_model slta_rx_model_inst (.pclk(pclk), .presetn(presetn), .lane_symbol(sym),
    .force_resync(frc), .link_sync_request_n(sync_n));

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // no local limit: only the watchdog ends a stuck access
  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_data();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, IDX_PLL_STATUS, 32'h0);
      n++;
    end
    while (rd[1:0] !== 2'h2 && n < 200);
  endtask

  // mfc pulses just after the multiframe's last octet; the second pulse sees settled settings
  task automatic grab();
    for (int p = 0; p < 2; p++)
    begin
      do
        @(posedge pclk);
      while (mfc !== 1'b1);
    end
    oct[0] = sym;
    for (int i = 1; i < 5; i++)
    begin
      @(posedge pclk);
      oct[i] = sym;
    end
  endtask

  // running disparity of the line must stay within one symbol's swing
  always @(posedge pclk)
  begin
    if (rd_on && presetn && sym !== 10'h0)
    begin
      acc = acc + $countones(sym) - 5;
      if (acc < 0 || acc > 1)
        chk(acc, 0);
    end
    if (sync_n && !seen && sym !== 10'h0FA && sym !== 10'h305)
    begin
      first_ilas = sym;
      seen = 1'b1;
    end
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    pll <= 1'b1;
    chk({pwr, dee, lvl, rate}, {1'b1, 1'b0, 4'h0, 4'h0});
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ridx[i], 32'h0);
      chk(rd, rexp[i]);
    end
    apb(1'b0, 12'hFFF, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, IDX_LINK_PARAMS, 32'hB303);
    frc <= 1'b0;
    wait_data();
    chk(rd[7], 1'b1);
    chk(rd[1:0], 2'h2);
    chk((first_ilas === 10'h0F4) || (first_ilas === 10'h30B), 1'b1);
    repeat (40) @(posedge pclk);
    frc <= 1'b1;
    @(posedge pclk);
    frc <= 1'b0;
    repeat (4) @(posedge pclk);
    chk((sym === 10'h0FA) || (sym === 10'h305), 1'b1);
    wait_data();
    chk(rd[1:0], 2'h2);
    rd_on <= 1'b0;
    apb(1'b1, IDX_LINK_PARAMS, 32'h3303);
    apb(1'b1, IDX_LINK_CTRL, 32'h0);
    apb(1'b1, IDX_ENC_CTRL, 32'h4);
    grab();
    chk({oct[1], oct[2], oct[3], oct[4]}, {10'h012, 10'h034, 10'h056, 10'h078});
    apb(1'b1, IDX_LINK_PARAMS, 32'h7303);
    grab();
    chk({oct[1], oct[2], oct[3], oct[4]}, {10'h012, 10'h034, 10'h05E, 10'h06F});
    apb(1'b1, IDX_LINK_PARAMS, 32'h3303);
    apb(1'b1, IDX_OUT_FORMAT, 32'h1);
    grab();
    chk({oct[1], oct[2], oct[3], oct[4]}, {10'h092, 10'h034, 10'h0D6, 10'h078});
    apb(1'b1, IDX_OUT_FORMAT, 32'h0);
    apb(1'b1, IDX_LINK_CTRL, 32'h10);
    grab();
    chk({oct[0], oct[4]}, {10'h17C, 10'h1FC});
    apb(1'b1, IDX_ENC_CTRL, 32'h6);
    grab();
    chk(oct[0], 10'h283);
    apb(1'b1, IDX_DEEMPH_EN, 32'h1);
    apb(1'b1, IDX_DEEMPH_LVL, 32'h5);
    apb(1'b1, IDX_LANE_RATE, 32'h10);
    apb(1'b1, IDX_LINK_CTRL, 32'h11);
    repeat (2) @(posedge pclk);
    chk({pwr, dee, lvl, rate}, {1'b0, 1'b1, 4'h5, 4'h1});
    conclude();
  end
endmodule // slta_encoder_tb
`default_nettype wire
